// *** emad_params.svh ***
// Address constants for the extended memory address decoder
`ifndef EMAD_PARAMS_SVH
`define EMAD_PARAMS_SVH

`define EMAD_LEGACY_SMM_BASE    32'h000A_0000
`define EMAD_HIGH_SEG_MASK      32'h0001_FFFF
`define EMAD_HIGH_SEG_BASE_DEF  32'hFED2_0000
`define EMAD_TOP_SEG_MIN_KB     23'h00_0080
`define EMAD_TOP_SEG_MAX        32'h0010_0000
`define EMAD_APIC_BASE          32'hFEC0_0000
`define EMAD_APIC_LAST          32'hFECF_FFFF
`define EMAD_APIC_SLOT_LAST     32'hFEC0_FFFF
`define EMAD_MID_HUB_BASE       32'hFED0_0000
`define EMAD_MID_HUB_LAST       32'hFFDF_FFFF
`define EMAD_HIGH_BIOS_BASE     32'hFFE0_0000
`define EMAD_WIN_BASE_LOW       20'h0_0000
`define EMAD_WIN_LIMIT_LOW      20'hF_FFFF
`define EMAD_APT_MIN_SIZE       32'h0040_0000
`define EMAD_DRIVE_COMPENSATION_MASK         32'h0000_0FFF
`define EMAD_GFX_CFG_MASK       32'h0000_0FFF
`define EMAD_IGD_MMIO_MASK      32'h0007_FFFF
`define EMAD_PAGE_MASK          32'h0000_0FFF
`define EMAD_CMD_MEM_EN_BIT     1
`define EMAD_APT_PAGES_DEF      1024
`define EMAD_FRAME_W_DEF        20

`endif

// *** emad_pkg.sv ***
// Types shared by the extended memory address decoder
package emad_pkg;
    typedef enum logic [1:0] {EMAD_SRC_HOST, EMAD_SRC_HUB, EMAD_SRC_AGP} emad_src_e;
    typedef enum logic [2:0] {
        EMAD_TGT_NONE, EMAD_TGT_DRAM, EMAD_TGT_HUB, EMAD_TGT_AGP,
        EMAD_TGT_IGD, EMAD_TGT_INTERNAL, EMAD_TGT_TERMINATE
    } emad_tgt_e;
    typedef enum logic [3:0] {
        EMAD_RGN_MAIN, EMAD_RGN_HIGH_SEG, EMAD_RGN_TOP_SEG, EMAD_RGN_PCI,
        EMAD_RGN_DRIVE_COMPENSATION, EMAD_RGN_GFX, EMAD_RGN_AGP_WIN, EMAD_RGN_APERTURE,
        EMAD_RGN_APIC, EMAD_RGN_MID_HUB, EMAD_RGN_BIOS
    } emad_rgn_e;
    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
        emad_src_e   src;
        logic        smm;
        logic        writeback;
        logic        write;
    } emad_req_s;
    typedef struct packed {
        logic        valid;
        emad_tgt_e   tgt;
        emad_rgn_e   region;
        logic [31:0] addr;
        logic [3:0]  apic_unit;
    } emad_route_s;
    typedef struct packed {
        logic        high_seg_en;
        logic        top_seg_en;
        logic [1:0]  smm_ram_control_size_select;
        logic [31:0] top_of_usable_dram;
        logic [22:0] installed_dram_kb;
        logic [31:0] drive_compensation_base;
        logic        igd_en;
        logic [31:0] gfx_cfg_base;
        logic [31:0] igd_mmio_base;
        logic        agp_en;
        logic [15:0] agp_bridge_command;
        logic [15:0] agp_window_base;
        logic [15:0] agp_window_limit;
        logic [15:0] agp_prefetch_window_base;
        logic [15:0] agp_prefetch_window_limit;
        logic [31:0] aperture_base;
        logic [2:0]  aperture_size;
    } emad_cfg_s;
endpackage : emad_pkg

// *** emad_win_match.sv ***
// Base/limit window comparator with 1 MB granularity
`timescale 1ns/1ps
`include "emad_params.svh"
module emad_win_match (
    input  wire logic        i_enable,
    input  wire logic [31:0] i_addr,
    input  wire logic [15:0] i_base,
    input  wire logic [15:0] i_limit,
    output logic             o_hit
);
    logic [31:0] lo;
    logic [31:0] hi;
    assign lo    = {i_base[15:4], `EMAD_WIN_BASE_LOW};
    assign hi    = {i_limit[15:4], `EMAD_WIN_LIMIT_LOW};
    assign o_hit = i_enable && (i_addr >= lo) && (i_addr <= hi);
endmodule : emad_win_match

// *** emad_gtt.sv ***
// Aperture translation table: page index to DRAM page frame
`timescale 1ns/1ps
module emad_gtt #(
    parameter int DEPTH   = 1024,
    parameter int FRAME_W = 20,
    parameter int IDX_W   = $clog2(DEPTH)
) (
    input  wire logic               i_clk,
    input  wire logic               i_we,
    input  wire logic [IDX_W-1:0]   i_windex,
    input  wire logic [FRAME_W-1:0] i_wframe,
    input  wire logic [IDX_W-1:0]   i_rindex,
    output logic      [FRAME_W-1:0] o_rframe
);
    logic [FRAME_W-1:0] table_mem [DEPTH];

    always_ff @(posedge i_clk) begin
        if (i_we) begin
            table_mem[i_windex] <= i_wframe;
        end
    end

    assign o_rframe = table_mem[i_rindex];
endmodule : emad_gtt

// *** emad_decoder.sv ***
// Extended memory (1 MB to 4 GB) address decoder and router
//
// Functional notes
// - SMM host access to enabled high segment goes to A0000h-BFFFFh in DRAM.
// - Non-SMM host access without write-back to enabled high or top segment terminates on host bus.
// - Non-SMM write-back to enabled high segment still remaps into SMM space.
// - Non-SMM write-back to enabled top segment goes to physical SMM memory.
// - Hub link and AGP cycles never reach enabled SMM space.
// - DRAM behind high segment addresses is never remapped nor reached.
// - Top segment is at most 1 MB, directly above top of usable DRAM.
// - SMM host access to enabled top segment reaches DRAM untranslated.
// - Size select field chooses extended SMM space size.
// - Other accesses in the enabled extended SMM range go to hub link.
// - Reported memory equals installed DRAM minus top segment size while top segment is enabled, else installed DRAM.
// - Top of DRAM to 4 GB defaults to hub link, except compensation MMIO.
// - With internal graphics, config and MMIO ranges go to graphics unit.
// - With AGP, windows go to AGP and aperture goes to DRAM.
// - Window registers give A[31:20]; base low zero, limit low FFFFFh.
// - Window claims address when base <= address <= limit, both windows.
// - Windows active only while bridge command memory enable is set.
// - APIC units sit in 4 KB slots from APIC base, routed to hub link.
// - Range between APIC space and high BIOS goes to hub link, except an enabled high segment inside it.
// - Top 2 MB high BIOS goes to hub link.
// - Host aperture hits translate through table; others route by decode.
`timescale 1ns/1ps
`include "emad_params.svh"
module emad_decoder
    import emad_pkg::*;
#(
    parameter logic [31:0] HIGH_SEG_BASE = `EMAD_HIGH_SEG_BASE_DEF,
    parameter int          APT_PAGES     = `EMAD_APT_PAGES_DEF,
    parameter int          FRAME_W       = `EMAD_FRAME_W_DEF,
    parameter int          IDX_W         = $clog2(APT_PAGES)
) (
    input  wire logic               i_clk,
    input  wire logic               i_resetn,
    input  wire emad_req_s          i_req,
    input  wire emad_cfg_s          i_cfg,
    input  wire logic               i_gtt_we,
    input  wire logic [IDX_W-1:0]   i_gtt_index,
    input  wire logic [FRAME_W-1:0] i_gtt_frame,
    output emad_route_s             o_route,
    output logic      [22:0]        o_avail_mem_kb
);
    // Segment and range hits
    logic [22:0] top_seg_kb;
    logic [31:0] top_seg_size;
    logic [31:0] top_seg_end;
    logic        hit_high;
    logic        hit_top;
    logic        hit_main;
    logic        hit_drive_compensation;
    logic        hit_gfx;
    logic        hit_apic;
    logic        hit_apic_slot;
    logic        hit_mid;
    logic        hit_bios;
    logic        hit_apt;
    logic        mem_en;
    logic [1:0]  win_hit;
    logic [15:0] win_base  [2];
    logic [15:0] win_limit [2];
    logic [31:0] apt_mask;
    logic [31:0] apt_off;
    logic [FRAME_W-1:0] apt_frame;
    logic        is_host;
    emad_route_s next_route;

    function automatic logic in_masked(input logic [31:0] a, input logic [31:0] base,
                                       input logic [31:0] mask);
        in_masked = ((a & ~mask) == (base & ~mask));
    endfunction : in_masked

    function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo,
                                      input logic [31:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction : in_range

    // Top segment sits right above usable DRAM, 128 KB up to 1 MB
    assign top_seg_kb   = `EMAD_TOP_SEG_MIN_KB << i_cfg.smm_ram_control_size_select;
    assign top_seg_size = {top_seg_kb[21:0], 10'h000};
    assign top_seg_end  = i_cfg.top_of_usable_dram + top_seg_size;

    assign is_host  = (i_req.src == EMAD_SRC_HOST);
    assign hit_high = i_cfg.high_seg_en && in_masked(i_req.addr, HIGH_SEG_BASE,
                                                     `EMAD_HIGH_SEG_MASK);
    assign hit_top  = i_cfg.top_seg_en && (i_req.addr >= i_cfg.top_of_usable_dram)
                      && (i_req.addr < top_seg_end);
    assign hit_main = (i_req.addr < i_cfg.top_of_usable_dram);

    assign hit_drive_compensation = in_masked(i_req.addr, i_cfg.drive_compensation_base, `EMAD_DRIVE_COMPENSATION_MASK);
    assign hit_gfx   = i_cfg.igd_en &&
                       (in_masked(i_req.addr, i_cfg.gfx_cfg_base, `EMAD_GFX_CFG_MASK) ||
                        in_masked(i_req.addr, i_cfg.igd_mmio_base, `EMAD_IGD_MMIO_MASK));
    assign hit_apic      = in_range(i_req.addr, `EMAD_APIC_BASE, `EMAD_APIC_LAST);
    assign hit_apic_slot = in_range(i_req.addr, `EMAD_APIC_BASE, `EMAD_APIC_SLOT_LAST);
    assign hit_mid       = in_range(i_req.addr, `EMAD_MID_HUB_BASE, `EMAD_MID_HUB_LAST);
    assign hit_bios      = (i_req.addr >= `EMAD_HIGH_BIOS_BASE);

    // AGP windows gated by bridge memory enable
    assign mem_en       = i_cfg.agp_en && i_cfg.agp_bridge_command[`EMAD_CMD_MEM_EN_BIT];
    assign win_base[0]  = i_cfg.agp_window_base;
    assign win_limit[0] = i_cfg.agp_window_limit;
    assign win_base[1]  = i_cfg.agp_prefetch_window_base;
    assign win_limit[1] = i_cfg.agp_prefetch_window_limit;

    for (genvar w = 0; w < 2; w++) begin : g_win
        emad_win_match u_win (
            .i_enable (mem_en),
            .i_addr   (i_req.addr),
            .i_base   (win_base[w]),
            .i_limit  (win_limit[w]),
            .o_hit    (win_hit[w])
        );
    end

    // Aperture: power-of-two size from 4 MB, pages looked up in table
    assign apt_mask = (`EMAD_APT_MIN_SIZE << i_cfg.aperture_size) - 32'h0000_0001;
    assign apt_off  = i_req.addr - i_cfg.aperture_base;
    assign hit_apt  = i_cfg.agp_en && in_masked(i_req.addr, i_cfg.aperture_base, apt_mask)
                      && (apt_off[31:12] < 20'(APT_PAGES));

    emad_gtt #(
        .DEPTH   (APT_PAGES),
        .FRAME_W (FRAME_W),
        .IDX_W   (IDX_W)
    ) u_gtt (
        .i_clk    (i_clk),
        .i_we     (i_gtt_we),
        .i_windex (i_gtt_index),
        .i_wframe (i_gtt_frame),
        .i_rindex (apt_off[IDX_W+11:12]),
        .o_rframe (apt_frame)
    );

    // Priority decode
    always_comb begin
        next_route           = '0;
        next_route.valid     = i_req.valid;
        next_route.addr      = i_req.addr;
        next_route.tgt       = EMAD_TGT_HUB;
        next_route.region    = EMAD_RGN_PCI;
        next_route.apic_unit = 4'h0;
        if (hit_high) begin
            next_route.region = EMAD_RGN_HIGH_SEG;
            if (!is_host) begin
                next_route.tgt = EMAD_TGT_HUB;
            end else if (i_req.smm || i_req.writeback) begin
                next_route.tgt  = EMAD_TGT_DRAM;
                next_route.addr = `EMAD_LEGACY_SMM_BASE |
                                  (i_req.addr & `EMAD_HIGH_SEG_MASK);
            end else begin
                next_route.tgt = EMAD_TGT_TERMINATE;
            end
        end else if (hit_top) begin
            next_route.region = EMAD_RGN_TOP_SEG;
            if (!is_host) begin
                next_route.tgt = EMAD_TGT_HUB;
            end else if (i_req.smm || i_req.writeback) begin
                next_route.tgt = EMAD_TGT_DRAM;
            end else begin
                next_route.tgt = EMAD_TGT_TERMINATE;
            end
        end else if (hit_main) begin
            next_route.tgt    = EMAD_TGT_DRAM;
            next_route.region = EMAD_RGN_MAIN;
        end else if (hit_apic) begin
            next_route.tgt    = EMAD_TGT_HUB;
            next_route.region = EMAD_RGN_APIC;
            if (hit_apic_slot) begin
                next_route.apic_unit = i_req.addr[15:12];
            end
        end else if (hit_mid) begin
            next_route.tgt    = EMAD_TGT_HUB;
            next_route.region = EMAD_RGN_MID_HUB;
        end else if (hit_bios) begin
            next_route.tgt    = EMAD_TGT_HUB;
            next_route.region = EMAD_RGN_BIOS;
        end else if (hit_drive_compensation) begin
            next_route.tgt    = EMAD_TGT_INTERNAL;
            next_route.region = EMAD_RGN_DRIVE_COMPENSATION;
        end else if (hit_gfx) begin
            next_route.tgt    = EMAD_TGT_IGD;
            next_route.region = EMAD_RGN_GFX;
        end else if (|win_hit) begin
            next_route.tgt    = EMAD_TGT_AGP;
            next_route.region = EMAD_RGN_AGP_WIN;
        end else if (hit_apt) begin
            next_route.tgt    = EMAD_TGT_DRAM;
            next_route.region = EMAD_RGN_APERTURE;
            if (is_host) begin
                next_route.addr = {apt_frame, i_req.addr[11:0]};
            end
        end else begin
            next_route.tgt    = EMAD_TGT_HUB;
            next_route.region = EMAD_RGN_PCI;
        end
    end

    // Registered routing result
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_route <= '0;
        end else begin
            o_route <= next_route;
        end
    end

    // Reported system memory
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_avail_mem_kb <= 23'h00_0000;
        end else if (i_cfg.top_seg_en) begin
            o_avail_mem_kb <= i_cfg.installed_dram_kb - top_seg_kb;
        end else begin
            o_avail_mem_kb <= i_cfg.installed_dram_kb;
        end
    end

    // Checks
    property p_high_smm_alias;
        @(posedge i_clk) disable iff (!i_resetn)
        (i_req.valid && hit_high && is_host && i_req.smm) |=>
            (o_route.tgt == EMAD_TGT_DRAM) &&
            (o_route.addr == (`EMAD_LEGACY_SMM_BASE | ($past(i_req.addr) & `EMAD_HIGH_SEG_MASK)));
    endproperty
    a_high_smm_alias: assert property (p_high_smm_alias)
        else $error("SMM high segment access not aliased to legacy range");

    property p_nonsmm_term;
        @(posedge i_clk) disable iff (!i_resetn)
        (i_req.valid && (hit_high || hit_top) && is_host && !i_req.smm && !i_req.writeback)
            |=> (o_route.tgt == EMAD_TGT_TERMINATE);
    endproperty
    a_nonsmm_term: assert property (p_nonsmm_term)
        else $error("Non-SMM segment access not terminated");

    property p_high_wb;
        @(posedge i_clk) disable iff (!i_resetn)
        (hit_high && is_host && !i_req.smm && i_req.writeback) |=>
            (o_route.tgt == EMAD_TGT_DRAM) && (o_route.addr[31:17] == 15'h0005);
    endproperty
    a_high_wb: assert property (p_high_wb)
        else $error("High segment write-back not remapped");

    property p_top_same_addr;
        @(posedge i_clk) disable iff (!i_resetn)
        (!hit_high && hit_top && is_host && (i_req.smm || i_req.writeback)) |=>
            (o_route.tgt == EMAD_TGT_DRAM) && (o_route.addr == $past(i_req.addr));
    endproperty
    a_top_same_addr: assert property (p_top_same_addr)
        else $error("Top segment access not sent to DRAM at same address");

    property p_ext_blocked;
        @(posedge i_clk) disable iff (!i_resetn)
        ((hit_high || hit_top) && !is_host) |=> (o_route.tgt == EMAD_TGT_HUB);
    endproperty
    a_ext_blocked: assert property (p_ext_blocked)
        else $error("External master reached SMM space");

    property p_high_dram_hidden;
        @(posedge i_clk) disable iff (!i_resetn)
        (o_route.tgt == EMAD_TGT_DRAM && o_route.region != EMAD_RGN_APERTURE)
            |-> !in_masked(o_route.addr, HIGH_SEG_BASE, `EMAD_HIGH_SEG_MASK)
                || (o_route.region == EMAD_RGN_MAIN);
    endproperty
    a_high_dram_hidden: assert property (p_high_dram_hidden)
        else $error("DRAM behind high segment became reachable");

    property p_top_seg_max;
        @(posedge i_clk) disable iff (!i_resetn)
        top_seg_size <= `EMAD_TOP_SEG_MAX;
    endproperty
    a_top_seg_max: assert property (p_top_seg_max)
        else $error("Top segment larger than 1 MB");

    property p_avail_mem;
        @(posedge i_clk) disable iff (!i_resetn)
        (i_cfg.top_seg_en ##1 $stable(i_cfg.installed_dram_kb)) |->
            (o_avail_mem_kb == i_cfg.installed_dram_kb - $past(top_seg_kb));
    endproperty
    a_avail_mem: assert property (p_avail_mem)
        else $error("Reported memory not reduced by top segment size");

    property p_win_gated;
        @(posedge i_clk) disable iff (!i_resetn)
        !mem_en |=> (o_route.tgt != EMAD_TGT_AGP);
    endproperty
    a_win_gated: assert property (p_win_gated)
        else $error("AGP route while memory enable clear");

    property p_win_claim;
        @(posedge i_clk) disable iff (!i_resetn)
        (mem_en && !hit_high && !hit_top && !hit_main && !hit_apic && !hit_mid && !hit_bios
         && !hit_drive_compensation && !hit_gfx &&
         (i_req.addr[31:20] >= i_cfg.agp_window_base[15:4]) &&
         (i_req.addr[31:20] <= i_cfg.agp_window_limit[15:4])) |=>
            (o_route.tgt == EMAD_TGT_AGP);
    endproperty
    a_win_claim: assert property (p_win_claim)
        else $error("Address inside AGP window not claimed");

    property p_pf_win_claim;
        @(posedge i_clk) disable iff (!i_resetn)
        (mem_en && !hit_high && !hit_top && !hit_main && !hit_apic && !hit_mid && !hit_bios
         && !hit_drive_compensation && !hit_gfx &&
         (i_req.addr[31:20] >= i_cfg.agp_prefetch_window_base[15:4]) &&
         (i_req.addr[31:20] <= i_cfg.agp_prefetch_window_limit[15:4])) |=>
            (o_route.tgt == EMAD_TGT_AGP);
    endproperty
    a_pf_win_claim: assert property (p_pf_win_claim)
        else $error("Address inside prefetchable AGP window not claimed");

    property p_fixed_hub;
        @(posedge i_clk) disable iff (!i_resetn)
        (!hit_high && !hit_top && !hit_main && (hit_mid || hit_bios)) |=>
            (o_route.tgt == EMAD_TGT_HUB) && (o_route.addr == $past(i_req.addr));
    endproperty
    a_fixed_hub: assert property (p_fixed_hub)
        else $error("Fixed hub range not routed to hub link");

    property p_apic_slot;
        @(posedge i_clk) disable iff (!i_resetn)
        (!hit_high && !hit_top && !hit_main && hit_apic_slot) |=>
            (o_route.tgt == EMAD_TGT_HUB) && (o_route.apic_unit == $past(i_req.addr[15:12]));
    endproperty
    a_apic_slot: assert property (p_apic_slot)
        else $error("APIC slot not routed or unit wrong");

    property p_apt_translate;
        @(posedge i_clk) disable iff (!i_resetn)
        // Table is not reset: only real requests may rely on written entries
        (i_req.valid && next_route.region == EMAD_RGN_APERTURE && is_host) |=>
            (o_route.tgt == EMAD_TGT_DRAM) && (o_route.addr[31:12] == $past(apt_frame))
            && (o_route.addr[11:0] == $past(i_req.addr[11:0]));
    endproperty
    a_apt_translate: assert property (p_apt_translate)
        else $error("Aperture access not translated to DRAM");

    property p_drive_compensation;
        @(posedge i_clk) disable iff (!i_resetn)
        (next_route.region == EMAD_RGN_DRIVE_COMPENSATION) |=> (o_route.tgt == EMAD_TGT_INTERNAL);
    endproperty
    a_drive_compensation: assert property (p_drive_compensation)
        else $error("Compensation MMIO not kept internal");
endmodule : emad_decoder

// *** emad_host_model.sv ***
// Requester model for host, hub link and AGP masters issuing memory cycles
`timescale 1ns/1ps
module emad_host_model
    import emad_pkg::*;
(
    input  wire logic      i_resetn,
    input  wire emad_req_s i_cycle,
    output emad_req_s      o_req
);
    // No cycle leaves a master while the decoder is held in reset
    assign o_req = i_resetn ? i_cycle : '0;
endmodule : emad_host_model

// *** emad_decoder_tb_top.sv ***
// Self-checking bench for the extended memory address decoder
`timescale 1ns/1ps
module emad_decoder_tb_top
    import emad_pkg::*;
;
    localparam int APT = 16;
    localparam logic [31:0] HSB = 32'hFED2_0000;
    localparam logic [31:0] ANCH [22] = '{
        32'h0010_0000, 32'h1000_0000, 32'h1002_0000, 32'h1004_0000, 32'h1008_0000,
        32'h1010_0000, 32'hFED2_0000, 32'hFED4_0000, 32'hFEC0_0000, 32'hFEC0_F000,
        32'hFEC1_0000, 32'hFED0_0000, 32'hFFE0_0000, 32'hE000_0000, 32'hE000_1000,
        32'hE008_0000, 32'hD000_0000, 32'hD010_0000, 32'hC000_0000, 32'hC200_0000,
        32'h8000_0000, 32'h8001_0000};
    logic        clk  = 1'b0;
    logic        rstn = 1'b0;
    emad_req_s   cyc;
    emad_req_s   req;
    emad_cfg_s   cfg;
    logic        gwe;
    logic [3:0]  gidx;
    logic [19:0] gfrm;
    emad_route_s route;
    logic [22:0] avail;
    logic [19:0] gtt_ref [APT];
    logic [31:0] lf;
    emad_req_s   q;
    emad_cfg_s   c;
    emad_route_s e_cur;
    emad_route_s e_prev;
    logic [22:0] m_cur;
    logic [22:0] m_prev;
    int          n_mismatch = 0;
    int          num_checks = 0;

    always #25 clk = ~clk;

    emad_host_model emad_host_model_i (.i_resetn(rstn), .i_cycle(cyc), .o_req(req));
    emad_decoder #(.APT_PAGES(APT)) emad_decoder_i (
        .i_clk(clk), .i_resetn(rstn), .i_req(req), .i_cfg(cfg), .i_gtt_we(gwe),
        .i_gtt_index(gidx), .i_gtt_frame(gfrm), .o_route(route), .o_avail_mem_kb(avail));

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return (x >> 1) ^ (x[0] ? 32'hA300_0001 : 32'h0000_0000);
    endfunction : lfsr

    function automatic logic win(input logic [31:0] a, input logic [15:0] b,
                                 input logic [15:0] l);
        return a[31:20] >= b[15:4] && a[31:20] <= l[15:4];
    endfunction : win

    function automatic emad_route_s ref_route(input emad_req_s rq, input emad_cfg_s cf);
        emad_route_s r;
        logic [31:0] a;
        logic [31:0] seg;
        logic [31:0] off;
        logic        hst;
        logic        keep;
        a    = rq.addr;
        hst  = rq.src == EMAD_SRC_HOST;
        keep = hst && (rq.smm || rq.writeback);
        seg  = 32'h0002_0000 << cf.smm_ram_control_size_select;
        off  = a - cf.aperture_base;
        r = '0;
        r.valid = rq.valid;
        r.addr = a;
        r.tgt = EMAD_TGT_HUB;
        r.region = EMAD_RGN_PCI;
        if (cf.high_seg_en && a >= HSB && a < HSB + 32'h0002_0000) begin
            r.region = EMAD_RGN_HIGH_SEG;
            if (keep) begin
                r.tgt = EMAD_TGT_DRAM;
                r.addr = 32'h000A_0000 | {15'h0000, a[16:0]};
            end else if (hst) r.tgt = EMAD_TGT_TERMINATE;
        end else if (cf.top_seg_en && a >= cf.top_of_usable_dram
                     && a - cf.top_of_usable_dram < seg) begin
            r.region = EMAD_RGN_TOP_SEG;
            if (keep) r.tgt = EMAD_TGT_DRAM;
            else if (hst) r.tgt = EMAD_TGT_TERMINATE;
        end else if (a < cf.top_of_usable_dram) begin
            r.tgt = EMAD_TGT_DRAM;
            r.region = EMAD_RGN_MAIN;
        end else if (a >= 32'hFEC0_0000 && a <= 32'hFECF_FFFF) begin
            r.region = EMAD_RGN_APIC;
            if (a <= 32'hFEC0_FFFF) r.apic_unit = a[15:12];
        end else if (a >= 32'hFFE0_0000) r.region = EMAD_RGN_BIOS;
        else if (a >= 32'hFED0_0000) r.region = EMAD_RGN_MID_HUB;
        else if (a[31:12] == cf.drive_compensation_base[31:12]) begin
            r.tgt = EMAD_TGT_INTERNAL;
            r.region = EMAD_RGN_DRIVE_COMPENSATION;
        end else if (cf.igd_en && (a[31:12] == cf.gfx_cfg_base[31:12]
                     || a[31:19] == cf.igd_mmio_base[31:19])) begin
            r.tgt = EMAD_TGT_IGD;
            r.region = EMAD_RGN_GFX;
        end else if (cf.agp_en && cf.agp_bridge_command[1]
                     && (win(a, cf.agp_window_base, cf.agp_window_limit)
                     || win(a, cf.agp_prefetch_window_base,
                            cf.agp_prefetch_window_limit))) begin
            r.tgt = EMAD_TGT_AGP;
            r.region = EMAD_RGN_AGP_WIN;
        end else if (cf.agp_en && a >= cf.aperture_base
                     && off < (32'h0040_0000 << cf.aperture_size) && off[31:12] < APT) begin
            r.tgt = EMAD_TGT_DRAM;
            r.region = EMAD_RGN_APERTURE;
            if (hst) r.addr = {gtt_ref[off[15:12]], a[11:0]};
        end
        return r;
    endfunction : ref_route

    task automatic chk_route(input emad_route_s got, input emad_route_s exp, input logic full);
        num_checks++;
        if (full ? got !== exp : got.valid !== exp.valid) begin
            n_mismatch++;
            $display("[ERR] t=%0t route got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_route

    task automatic chk_mem(input logic [22:0] got, input logic [22:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t avail got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_mem

    task automatic complete_run;
        $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : complete_run

    initial begin
        lf = 32'h7d0b;
        cyc = '0;
        gwe = 1'b0;
        gidx = '0;
        gfrm = '0;
        cfg = '0;
        // Ranges kept off APIC and high BIOS space
        cfg.top_of_usable_dram = 32'h1000_0000;
        cfg.installed_dram_kb = 23'h04_0000;
        cfg.drive_compensation_base = 32'hE000_0000;
        cfg.gfx_cfg_base = 32'hE000_1000;
        cfg.igd_mmio_base = 32'hE008_0000;
        cfg.agp_window_base = 16'hD000;
        cfg.agp_window_limit = 16'hD000;
        cfg.agp_prefetch_window_base = 16'hC000;
        cfg.agp_prefetch_window_limit = 16'hC1F0;
        cfg.aperture_base = 32'h8000_0000;
        repeat (16) @(posedge clk);
        chk_route(route, '0, 1'b1);
        chk_mem(avail, 23'h00_0000);
        rstn <= 1'b1;
        for (int i = 0; i < 1500; i++) begin
            @(posedge clk);
            lf = lfsr(lf);
            q.valid = i >= 16 && lf[3:0] != 4'h0;
            q.addr = ANCH[lf[8:4] % 22] + {30'h0000_0000, lf[10:9]} - 32'h0000_0002;
            q.src = emad_src_e'(2'(lf[12:11] % 2'd3));
            q.smm = lf[13];
            q.writeback = lf[14];
            q.write = lf[15];
            c = cfg;
            c.high_seg_en = lf[16];
            c.top_seg_en = lf[17];
            c.smm_ram_control_size_select = lf[19:18];
            c.igd_en = lf[20];
            c.agp_en = lf[21] | lf[22];
            c.agp_bridge_command = {14'h0000, lf[23], 1'b0};
            c.aperture_size = lf[26:24];
            c.agp_window_base[3:0] = lf[30:27];
            c.agp_prefetch_window_limit[3:0] = lf[30:27];
            e_cur = ref_route(q, c);
            m_cur = c.installed_dram_kb
                    - (c.top_seg_en ? 23'h00_0080 << c.smm_ram_control_size_select : 23'h00_0000);
            cyc <= q;
            cfg <= c;
            gwe <= i < 16 || lf[31];
            gidx <= i < 16 ? 4'(i) : lf[7:4];
            gfrm <= lf[27:8];
            if (i < 16 || lf[31]) gtt_ref[i < 16 ? 4'(i) : lf[7:4]] = lf[27:8];
            @(negedge clk);
            if (i > 0) begin
                chk_route(route, e_prev, e_prev.valid);
                chk_mem(avail, m_prev);
            end
            e_prev = e_cur;
            m_prev = m_cur;
        end
        complete_run();
    end
endmodule : emad_decoder_tb_top
